// >>> hdl/ifod_pkg.sv
// ifod_pkg: field layout, primary codes, function codes and op enumeration
// assumes 32-bit instruction words, opcode in the top six bits
package ifod_pkg;

  // field positions
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int FPF_HI = 15;
  localparam int FPF_LO = 5;
  localparam int OPF_HI = 11;
  localparam int OPF_LO = 5;
  localparam int MFC_HI = 15;
  localparam int MFC_LO = 0;
  localparam int MBR_HI = 15;
  localparam int MBR_LO = 14;
  localparam int PCF_HI = 25;
  localparam int PCF_LO = 0;

  // primary codes
  localparam logic [5:0] PRI_PCALL = 6'h00;
  localparam logic [5:0] PRI_INTA = 6'h10;
  localparam logic [5:0] PRI_INTL = 6'h11;
  localparam logic [5:0] PRI_FLTG = 6'h15;
  localparam logic [5:0] PRI_FLTI = 6'h16;
  localparam logic [5:0] PRI_MISC = 6'h18;
  localparam logic [5:0] PRI_JUMP = 6'h1a;
  localparam logic [5:0] PRI_FPTI = 6'h1c;
  localparam logic [5:0] PRI_FBRANCH_ZERO_OP = 6'h31;
  localparam logic [5:0] PRI_FBLT = 6'h32;
  localparam logic [5:0] PRI_FBLE = 6'h33;
  localparam logic [5:0] PRI_FBRANCH_NONZERO_OP = 6'h35;
  localparam logic [5:0] PRI_FBGE = 6'h36;
  localparam logic [5:0] PRI_FBGT = 6'h37;
  localparam logic [5:0] PRI_BRANCH_LOWCLEAR_OP = 6'h38;
  localparam logic [5:0] PRI_BEQ = 6'h39;
  localparam logic [5:0] PRI_BRANCH_LOWSET_OP = 6'h3c;
  localparam logic [5:0] PRI_BNE = 6'h3d;

  // operate function codes
  localparam logic [6:0] OPF_ADD_LONG_OP = 7'h00;
  localparam logic [6:0] OPF_ADD_QUAD_OP = 7'h20;
  localparam logic [6:0] OPF_ADDLV = 7'h40;
  localparam logic [6:0] OPF_ADDQV = 7'h60;
  localparam logic [6:0] OPF_CMP_UNSIGNED_LE_OP = 7'h3d;
  localparam logic [6:0] OPF_CMP_UNSIGNED_LT_OP = 7'h1d;
  localparam logic [6:0] OPF_CMOVLC = 7'h16;
  localparam logic [6:0] OPF_CMOVE_LOWSET_OP = 7'h14;
  localparam logic [6:0] OPF_FP_TO_INT_DOUBLE_OP = 7'h70;
  localparam logic [6:0] OPF_FP_TO_INT_SINGLE_OP = 7'h78;

  // floating function codes
  localparam logic [10:0] FPF_QUAD_TO_DOUBLE_OP = 11'h0be;
  localparam logic [10:0] FPF_QUAD_TO_SINGLE_OP = 11'h0bc;
  localparam logic [10:0] FPF_GFLOAT_TO_QUAD_OP = 11'h0af;

  // memory function codes
  localparam logic [15:0] MFC_FETCH = 16'h8000;
  localparam logic [15:0] MFC_FETCHM = 16'ha000;

  // memory-branch selectors
  localparam logic [1:0] MBR_JSR = 2'h1;
  localparam logic [1:0] MBR_RET = 2'h3;

  // instruction format classes
  typedef enum logic [2:0] {
    IFOD_FMT_NONE,
    IFOD_FMT_BRA,
    IFOD_FMT_FP,
    IFOD_FMT_MEM,
    IFOD_FMT_MFC,
    IFOD_FMT_MBR,
    IFOD_FMT_OPR,
    IFOD_FMT_PCD
  } ifod_fmt_t;

  // decoded operations
  typedef enum logic [4:0] {
    IFOD_OP_NONE,
    IFOD_OP_ADD_LONG,
    IFOD_OP_ADD_LONG_TRAP,
    IFOD_OP_ADD_QUAD,
    IFOD_OP_ADD_QUAD_TRAP,
    IFOD_OP_CMP_UNSIGNED_LE,
    IFOD_OP_CMP_UNSIGNED_LT,
    IFOD_OP_CMOVE_LOWCLEAR,
    IFOD_OP_CMOVE_LOWSET,
    IFOD_OP_BRANCH_LOWCLEAR,
    IFOD_OP_BRANCH_LOWSET,
    IFOD_OP_BRANCH_ZERO,
    IFOD_OP_BRANCH_NONZERO,
    IFOD_OP_FBRANCH_ZERO,
    IFOD_OP_FBRANCH_NONZERO,
    IFOD_OP_FBRANCH_NEG,
    IFOD_OP_FBRANCH_NONPOS,
    IFOD_OP_FBRANCH_NONNEG,
    IFOD_OP_FBRANCH_POS,
    IFOD_OP_QUAD_TO_DOUBLE,
    IFOD_OP_QUAD_TO_SINGLE,
    IFOD_OP_GFLOAT_TO_QUAD,
    IFOD_OP_PREFETCH,
    IFOD_OP_PREFETCH_MODIFY,
    IFOD_OP_SUBROUTINE_JUMP,
    IFOD_OP_SUBROUTINE_RETURN,
    IFOD_OP_FP_TO_INT_DOUBLE,
    IFOD_OP_FP_TO_INT_SINGLE,
    IFOD_OP_PRIVILEGED_CALL
  } ifod_op_t;

  // decoded result carried to the pipeline
  typedef struct packed {
    logic valid;
    logic illegal;
    ifod_fmt_t fmt;
    ifod_op_t op;
    logic [5:0] primary;
    logic [15:0] func;
    logic [25:0] pal_func;
    logic [31:0] word;
  } ifod_dec_t;

endpackage

// >>> hdl/ifod_fields.sv
// ifod_fields: pulls the format-specific fields out of an instruction word
// assumes a combinational caller on the same clock
`timescale 1ns/1ps
module ifod_fields (
  // instruction word
  input wire logic [31:0] word,
  // extracted fields
  output logic [5:0] primary,
  output logic [10:0] fp_func,
  output logic [6:0] opr_func,
  output logic [15:0] mfc_func,
  output logic [1:0] mbr_sel,
  output logic [25:0] pal_func
);

  // field slicing, fixed positions whatever the format
  assign primary = word[ifod_pkg::OPC_HI:ifod_pkg::OPC_LO];
  assign fp_func = word[ifod_pkg::FPF_HI:ifod_pkg::FPF_LO];
  assign opr_func = word[ifod_pkg::OPF_HI:ifod_pkg::OPF_LO];
  assign mfc_func = word[ifod_pkg::MFC_HI:ifod_pkg::MFC_LO];
  assign mbr_sel = word[ifod_pkg::MBR_HI:ifod_pkg::MBR_LO];
  assign pal_func = word[ifod_pkg::PCF_HI:ifod_pkg::PCF_LO];

endmodule

// >>> hdl/ifod_decoder.sv
// ifod_decoder: single-cycle format and operation decoder for 32-bit words
// assumes the fetch stage presents one word with a valid strobe per cycle
//
// Behaviour
// - primary code is the 6-bit top field and selects the format
// - floating format uses the 11-bit function code
// - integer operate format uses the 7-bit function code
// - memory-function format uses the 16-bit displacement as function
// - memory-branch format uses the top two displacement bits as selector
// - privileged call takes its function from the 26-bit field
// - all codes are hexadecimal, written primary dot function
// - 10.00/10.20 adds, 10.40/10.60 same adds with overflow trap
// - integer branches 38, 3c, 39, 3d by primary code alone
// - floating branches 31, 35, 32, 33, 36, 37 by primary code
// - 10.3d unsigned compare le, 10.1d unsigned compare lt
// - 16.0be quad to double, 16.0bc quad to single
// - 18.8000 prefetch, 18.a000 prefetch with modify intent
// - 1a selector 1 subroutine jump, 3 subroutine return
// - 1c.70 raw fp to int double move, 1c.78 single move
// - 15.0af converts legacy g-format value to quadword
// - 11.16 conditional move low clear, 11.14 low set
`timescale 1ns/1ps
module ifod_decoder (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // from fetch
  input wire logic IN_VALID,
  input wire logic [31:0] IN_WORD,
  // to pipeline
  output ifod_pkg::ifod_dec_t DEC_OUT,
  output logic DEC_VALID,
  output logic DEC_ILLEGAL
);

  ////////////////////////////////////////////////////////////////////////////
  // field extraction

  logic [5:0] primary;
  logic [10:0] fp_func;
  logic [6:0] opr_func;
  logic [15:0] mfc_func;
  logic [1:0] mbr_sel;
  logic [25:0] pal_func;

  ifod_fields u_fields (
    .word(IN_WORD),
    .primary(primary),
    .fp_func(fp_func),
    .opr_func(opr_func),
    .mfc_func(mfc_func),
    .mbr_sel(mbr_sel),
    .pal_func(pal_func)
  );

  ////////////////////////////////////////////////////////////////////////////
  // format class from primary code

  function automatic ifod_pkg::ifod_fmt_t fmt_of(input logic [5:0] pri);
    ifod_pkg::ifod_fmt_t f;
    f = ifod_pkg::IFOD_FMT_NONE;
    case (pri)
      ifod_pkg::PRI_PCALL: f = ifod_pkg::IFOD_FMT_PCD;
      ifod_pkg::PRI_INTA, ifod_pkg::PRI_INTL: f = ifod_pkg::IFOD_FMT_OPR;
      ifod_pkg::PRI_FPTI: f = ifod_pkg::IFOD_FMT_OPR;
      ifod_pkg::PRI_FLTG, ifod_pkg::PRI_FLTI: f = ifod_pkg::IFOD_FMT_FP;
      ifod_pkg::PRI_MISC: f = ifod_pkg::IFOD_FMT_MFC;
      ifod_pkg::PRI_JUMP: f = ifod_pkg::IFOD_FMT_MBR;
      ifod_pkg::PRI_FBRANCH_ZERO_OP, ifod_pkg::PRI_FBLT, ifod_pkg::PRI_FBLE,
      ifod_pkg::PRI_FBRANCH_NONZERO_OP, ifod_pkg::PRI_FBGE, ifod_pkg::PRI_FBGT,
      ifod_pkg::PRI_BRANCH_LOWCLEAR_OP, ifod_pkg::PRI_BEQ, ifod_pkg::PRI_BRANCH_LOWSET_OP,
      ifod_pkg::PRI_BNE: f = ifod_pkg::IFOD_FMT_BRA;
      default: f = ifod_pkg::IFOD_FMT_NONE;
    endcase
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operation decode, codes compared as hex values

  ifod_pkg::ifod_fmt_t fmt;
  ifod_pkg::ifod_op_t op;
  logic [15:0] func_sel;

  // format select, and
  always_comb begin
    fmt = fmt_of(primary);
  end

  // operation select by primary code and format-specific field
  always_comb begin
    op = ifod_pkg::IFOD_OP_NONE;
    func_sel = 16'h0000;
    case (primary)
      ifod_pkg::PRI_INTA: begin
        func_sel = {9'h000, opr_func};
        case (opr_func)
          ifod_pkg::OPF_ADD_LONG_OP: op = ifod_pkg::IFOD_OP_ADD_LONG;
          ifod_pkg::OPF_ADD_QUAD_OP: op = ifod_pkg::IFOD_OP_ADD_QUAD;
          ifod_pkg::OPF_ADDLV: op = ifod_pkg::IFOD_OP_ADD_LONG_TRAP;
          ifod_pkg::OPF_ADDQV: op = ifod_pkg::IFOD_OP_ADD_QUAD_TRAP;
          ifod_pkg::OPF_CMP_UNSIGNED_LE_OP: op = ifod_pkg::IFOD_OP_CMP_UNSIGNED_LE;
          ifod_pkg::OPF_CMP_UNSIGNED_LT_OP: op = ifod_pkg::IFOD_OP_CMP_UNSIGNED_LT;
          default: op = ifod_pkg::IFOD_OP_NONE;
        endcase
      end
      ifod_pkg::PRI_INTL: begin
        func_sel = {9'h000, opr_func};
        case (opr_func)
          ifod_pkg::OPF_CMOVLC: op = ifod_pkg::IFOD_OP_CMOVE_LOWCLEAR;
          ifod_pkg::OPF_CMOVE_LOWSET_OP: op = ifod_pkg::IFOD_OP_CMOVE_LOWSET;
          default: op = ifod_pkg::IFOD_OP_NONE;
        endcase
      end
      ifod_pkg::PRI_FPTI: begin
        func_sel = {9'h000, opr_func};
        case (opr_func)
          ifod_pkg::OPF_FP_TO_INT_DOUBLE_OP: op = ifod_pkg::IFOD_OP_FP_TO_INT_DOUBLE;
          ifod_pkg::OPF_FP_TO_INT_SINGLE_OP: op = ifod_pkg::IFOD_OP_FP_TO_INT_SINGLE;
          default: op = ifod_pkg::IFOD_OP_NONE;
        endcase
      end
      ifod_pkg::PRI_FLTI: begin
        func_sel = {5'h00, fp_func};
        case (fp_func)
          ifod_pkg::FPF_QUAD_TO_DOUBLE_OP: op = ifod_pkg::IFOD_OP_QUAD_TO_DOUBLE;
          ifod_pkg::FPF_QUAD_TO_SINGLE_OP: op = ifod_pkg::IFOD_OP_QUAD_TO_SINGLE;
          default: op = ifod_pkg::IFOD_OP_NONE;
        endcase
      end
      ifod_pkg::PRI_FLTG: begin
        func_sel = {5'h00, fp_func};
        case (fp_func)
          ifod_pkg::FPF_GFLOAT_TO_QUAD_OP: op = ifod_pkg::IFOD_OP_GFLOAT_TO_QUAD;
          default: op = ifod_pkg::IFOD_OP_NONE;
        endcase
      end
      ifod_pkg::PRI_MISC: begin
        func_sel = mfc_func;
        case (mfc_func)
          ifod_pkg::MFC_FETCH: op = ifod_pkg::IFOD_OP_PREFETCH;
          ifod_pkg::MFC_FETCHM: op = ifod_pkg::IFOD_OP_PREFETCH_MODIFY;
          default: op = ifod_pkg::IFOD_OP_NONE;
        endcase
      end
      ifod_pkg::PRI_JUMP: begin
        func_sel = {14'h0000, mbr_sel};
        case (mbr_sel)
          ifod_pkg::MBR_JSR: op = ifod_pkg::IFOD_OP_SUBROUTINE_JUMP;
          ifod_pkg::MBR_RET: op = ifod_pkg::IFOD_OP_SUBROUTINE_RETURN;
          default: op = ifod_pkg::IFOD_OP_NONE;
        endcase
      end
      ifod_pkg::PRI_PCALL: op = ifod_pkg::IFOD_OP_PRIVILEGED_CALL;
      ifod_pkg::PRI_BRANCH_LOWCLEAR_OP: op = ifod_pkg::IFOD_OP_BRANCH_LOWCLEAR;
      ifod_pkg::PRI_BRANCH_LOWSET_OP: op = ifod_pkg::IFOD_OP_BRANCH_LOWSET;
      ifod_pkg::PRI_BEQ: op = ifod_pkg::IFOD_OP_BRANCH_ZERO;
      ifod_pkg::PRI_BNE: op = ifod_pkg::IFOD_OP_BRANCH_NONZERO;
      ifod_pkg::PRI_FBRANCH_ZERO_OP: op = ifod_pkg::IFOD_OP_FBRANCH_ZERO;
      ifod_pkg::PRI_FBRANCH_NONZERO_OP: op = ifod_pkg::IFOD_OP_FBRANCH_NONZERO;
      ifod_pkg::PRI_FBLT: op = ifod_pkg::IFOD_OP_FBRANCH_NEG;
      ifod_pkg::PRI_FBLE: op = ifod_pkg::IFOD_OP_FBRANCH_NONPOS;
      ifod_pkg::PRI_FBGE: op = ifod_pkg::IFOD_OP_FBRANCH_NONNEG;
      ifod_pkg::PRI_FBGT: op = ifod_pkg::IFOD_OP_FBRANCH_POS;
      default: op = ifod_pkg::IFOD_OP_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output register

  ifod_pkg::ifod_dec_t dec_d, dec_q;

  // next decoded result, cleared when no word is offered
  always_comb begin
    dec_d = '0;
    if (IN_VALID) begin
      dec_d.valid = 1'b1;
      dec_d.illegal = (op == ifod_pkg::IFOD_OP_NONE);
      dec_d.fmt = fmt;
      dec_d.op = op;
      dec_d.primary = primary;
      dec_d.func = func_sel;
      dec_d.pal_func = (fmt == ifod_pkg::IFOD_FMT_PCD) ? pal_func : 26'h0000000;
      dec_d.word = IN_WORD;
    end
  end

  // registered stage, synchronous reset
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  assign DEC_OUT = dec_q;
  assign DEC_VALID = dec_q.valid;
  assign DEC_ILLEGAL = dec_q.valid & dec_q.illegal;

endmodule

// >>> dv/ifod_decoder_properties.sv
// ifod_decoder_properties: answer timing and code mapping checks on the decoder ports
// assumes registered answers one cycle after the taking edge
`timescale 1ns/1ps
module ifod_decoder_properties (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // fetch side
  input wire logic IN_VALID,
  input wire logic [31:0] IN_WORD,
  // pipeline side
  input ifod_pkg::ifod_dec_t DEC_OUT,
  input wire logic DEC_VALID,
  input wire logic DEC_ILLEGAL
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////////
  // a word offered whose masked bits match a code
  sequence s_take(logic [31:0] msk, logic [31:0] val);
    IN_VALID && ((IN_WORD & msk) == val);
  endsequence
  // the next answer carries that operation and is legal
  property p_map(logic [31:0] msk, logic [31:0] val, ifod_pkg::ifod_op_t op);
    s_take(msk, val) |=> DEC_OUT.op == op && !DEC_ILLEGAL;
  endproperty
  AST_LAT: assert property ($past(RSTN) |-> DEC_VALID == $past(IN_VALID))
    else $error("answer not one cycle after take");
  AST_PRI: assert property (DEC_VALID |-> DEC_OUT.word == $past(IN_WORD)
    && DEC_OUT.primary == DEC_OUT.word[31:26]) else $error("primary code wrong");
  AST_ILL: assert property (DEC_ILLEGAL ==
    (DEC_VALID && DEC_OUT.op == ifod_pkg::IFOD_OP_NONE)) else $error("illegal flag wrong");
  AST_PAL: assert property (s_take(32'hfc000000, 32'h00000000) |=> !DEC_ILLEGAL
    && DEC_OUT.pal_func == DEC_OUT.word[25:0]) else $error("call function wrong");
  AST_OPF: assert property (s_take(32'hfc000000, 32'h40000000) |=>
    DEC_OUT.fmt == ifod_pkg::IFOD_FMT_OPR && DEC_OUT.func == {9'h000, DEC_OUT.word[11:5]})
    else $error("operate format wrong");
  AST_ADDV: assert property (p_map(32'hfc000fe0, 32'h40000c00,
    ifod_pkg::IFOD_OP_ADD_QUAD_TRAP)) else $error("trapping add wrong");
  AST_QUAD_TO_SINGLE_OP: assert property (p_map(32'hfc00ffe0, 32'h58001780,
    ifod_pkg::IFOD_OP_QUAD_TO_SINGLE)) else $error("single conversion wrong");
  AST_FETCHM: assert property (p_map(32'hfc00ffff, 32'h6000a000,
    ifod_pkg::IFOD_OP_PREFETCH_MODIFY)) else $error("modify prefetch wrong");
  AST_JSR: assert property (p_map(32'hfc00c000, 32'h68004000,
    ifod_pkg::IFOD_OP_SUBROUTINE_JUMP)) else $error("subroutine jump wrong");
  AST_FP_TO_INT_SINGLE_OP: assert property (p_map(32'hfc000fe0, 32'h70000f00,
    ifod_pkg::IFOD_OP_FP_TO_INT_SINGLE)) else $error("single move wrong");
  AST_BRANCH_LOWSET_OP: assert property (p_map(32'hfc000000, 32'hf0000000,
    ifod_pkg::IFOD_OP_BRANCH_LOWSET)) else $error("low set branch wrong");
endmodule
bind ifod_decoder ifod_decoder_properties u_props (.CLOCK(CLOCK), .RSTN(RSTN),
  .IN_VALID(IN_VALID), .IN_WORD(IN_WORD), .DEC_OUT(DEC_OUT), .DEC_VALID(DEC_VALID),
  .DEC_ILLEGAL(DEC_ILLEGAL));

// >>> dv/ifod_fetch_model.sv
// ifod_fetch_model: fetch stage offering at most one word per cycle
// assumes the bench calls offer once for every cycle it wants driven
`timescale 1ns/1ps
module ifod_fetch_model (
  // clock
  input wire logic CLOCK,
  // to decoder
  output logic IN_VALID,
  output logic [31:0] IN_WORD
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle at time zero
  initial begin
    IN_VALID = 1'b0;
    IN_WORD = 32'h00000000;
  end
  // drive just after the edge; an idle word bus shows the inverse of its last value
  task automatic offer(input logic v, input logic [31:0] w);
    @(posedge CLOCK);
    #1;
    IN_VALID = v;
    IN_WORD = v ? w : ~IN_WORD;
  endtask
endmodule

// >>> dv/testbench.sv
// testbench: drives the decoder through the fetch model and checks every answer
// assumes a 25 MHz clock and one registered answer per taken word
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
  $display("FAIL %s expected %0h seen %0h", n, e, s); end end
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic in_valid;
  logic [31:0] in_word;
  ifod_pkg::ifod_dec_t dec_out;
  logic dec_valid;
  logic dec_illegal;
  logic took_q = 1'b0;
  logic [31:0] word_q = 32'h00000000;
  logic [31:0] rnd;
  logic [31:0] rv;
  ifod_pkg::ifod_op_t op_e;
  int num_errors = 0;
  int samples_checked = 0;
  // one code word per operation, in the order of the operation list
  logic [31:0] ops_w [28] = '{32'h40000000, 32'h40000800, 32'h40000400, 32'h40000c00,
    32'h400007a0, 32'h400003a0, 32'h440002c0, 32'h44000280,
    32'he0000000, 32'hf0000000, 32'he4000000, 32'hf4000000, 32'hc4000000,
    32'hd4000000, 32'hc8000000, 32'hcc000000, 32'hd8000000, 32'hdc000000,
    32'h580017c0, 32'h58001780, 32'h540015e0, 32'h60008000, 32'h6000a000,
    32'h68004000, 32'h6800c000, 32'h70000e00, 32'h70000f00, 32'h00000000};
  logic [31:0] bad_w [3] = '{32'h40000020, 32'hf8000000, 32'h68000000};
  ////////////////////////////////////////////////////////////////////////////////
  // expected operation: mask by format, then look the code up
  function automatic ifod_pkg::ifod_op_t exp_op(input logic [31:0] w);
    logic [31:0] m;
    case (w[31:26])
      6'h10, 6'h11, 6'h1c: m = 32'hfc000fe0;
      6'h15, 6'h16: m = 32'hfc00ffe0;
      6'h18: m = 32'hfc00ffff;
      6'h1a: m = 32'hfc00c000;
      default: m = 32'hfc000000;
    endcase
    exp_op = ifod_pkg::IFOD_OP_NONE;
    foreach (ops_w[i]) begin
      if ((w & m) === ops_w[i]) begin
        exp_op = ifod_pkg::ifod_op_t'(i + 1);
      end
    end
  endfunction
  // expected format class from the primary code alone
  function automatic ifod_pkg::ifod_fmt_t exp_fmt(input logic [5:0] p);
    case (p)
      6'h00: exp_fmt = ifod_pkg::IFOD_FMT_PCD;
      6'h10, 6'h11, 6'h1c: exp_fmt = ifod_pkg::IFOD_FMT_OPR;
      6'h15, 6'h16: exp_fmt = ifod_pkg::IFOD_FMT_FP;
      6'h18: exp_fmt = ifod_pkg::IFOD_FMT_MFC;
      6'h1a: exp_fmt = ifod_pkg::IFOD_FMT_MBR;
      6'h31, 6'h32, 6'h33, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h3c, 6'h3d:
        exp_fmt = ifod_pkg::IFOD_FMT_BRA;
      default: exp_fmt = ifod_pkg::IFOD_FMT_NONE;
    endcase
  endfunction
  // expected function field, zero-extended to sixteen bits
  function automatic logic [15:0] exp_func(input logic [31:0] w);
    case (w[31:26])
      6'h10, 6'h11, 6'h1c: exp_func = {9'h000, w[11:5]};
      6'h15, 6'h16: exp_func = {5'h00, w[15:5]};
      6'h18: exp_func = w[15:0];
      6'h1a: exp_func = {14'h0000, w[15:14]};
      default: exp_func = 16'h0000;
    endcase
  endfunction
  // clock
  always #20 clock = ~clock;
  // fetch model and decoder
  ifod_fetch_model u_fetch (.CLOCK(clock), .IN_VALID(in_valid), .IN_WORD(in_word));
  ifod_decoder u_dut (.CLOCK(clock), .RSTN(rstn), .IN_VALID(in_valid), .IN_WORD(in_word),
    .DEC_OUT(dec_out), .DEC_VALID(dec_valid), .DEC_ILLEGAL(dec_illegal));
  // remember what the last edge took
  always @(posedge clock) begin
    took_q <= rstn && in_valid;
    word_q <= in_word;
  end
  // compare the answer in mid cycle
  always @(negedge clock) begin
    op_e = exp_op(word_q);
    `CHK("valid", took_q, dec_valid)
    if (took_q) begin
      `CHK("op", op_e, dec_out.op)
      `CHK("illegal", op_e == ifod_pkg::IFOD_OP_NONE, dec_illegal)
      `CHK("word", word_q, dec_out.word)
      `CHK("primary", word_q[31:26], dec_out.primary)
      `CHK("fmt", exp_fmt(word_q[31:26]), dec_out.fmt)
      `CHK("func", exp_func(word_q), dec_out.func)
      `CHK("pal", word_q[25:0] & {26{word_q[31:26] == 6'h00}}, dec_out.pal_func)
    end else begin
      `CHK("idle", '0, dec_out)
    end
  end
  // verdict and end of run
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
  // main sequence
  initial begin
    void'($urandom(26));
    repeat (8) @(posedge clock);
    #1;
    rstn = 1'b1;
    foreach (ops_w[i]) u_fetch.offer(1'b1, ops_w[i]);
    foreach (bad_w[i]) u_fetch.offer(1'b1, bad_w[i]);
    $display("test directed done");
    for (int i = 0; i < 300; i++) begin
      rv = $urandom;
      rnd = $urandom;
      if (rv[0]) begin
        rnd = ops_w[rv[9:5] % 28] ^ {27'h0000000, rv[14:10]};
      end
      u_fetch.offer(rv[15] | rv[16], rnd);
    end
    $display("test random done");
    u_fetch.offer(1'b1, 32'h40000000);
    rstn = 1'b0;
    u_fetch.offer(1'b1, 32'hf0000000);
    u_fetch.offer(1'b1, 32'h00000000);
    rstn = 1'b1;
    u_fetch.offer(1'b1, 32'hd4000000);
    u_fetch.offer(1'b0, 32'h00000000);
    repeat (3) @(posedge clock);
    $display("test reset done");
    end_sim;
  end
endmodule
